// ---- common/srka_defs.svh ----
`ifndef SRKA_DEFS_SVH
`define SRKA_DEFS_SVH

// register byte offsets
`define SRKA_OFF_CTRL 8'h00
`define SRKA_OFF_CFG 8'h04
`define SRKA_OFF_STATUS 8'h08
`define SRKA_OFF_TIMER 8'h0c

// control register field positions
`define SRKA_CTRL_LVL_LO 8
`define SRKA_CTRL_DUAL_GO 12
`define SRKA_CTRL_DUAL_MOD 13
`define SRKA_CTRL_DEM_GO 14
`define SRKA_CTRL_DEM_DS 15
`define SRKA_CTRL_DEM_MOD 16

// reset values
`define SRKA_HOP_LIM_RST 4'h2
`define SRKA_LOCAL_SWITCH_IDENTIFIER_RST 8'hff

`endif

// ---- common/srka_pkg.sv ----
package srka_pkg;

   // packet kinds seen on receive and issued on transmit
   typedef enum logic [3:0] {
      SRKA_K_NONE,
      SRKA_K_REGISTRATION_RESPONSE,
      SRKA_K_PROMO_REQ,
      SRKA_K_PROMO_ACK,
      SRKA_K_DEMOTE,
      SRKA_K_ALV_REQ,
      SRKA_K_ALV_RSP,
      SRKA_K_ALV_ACK,
      SRKA_K_ARQ_DATA,
      SRKA_K_CONN_REQ,
      SRKA_K_CONN_CLS,
      SRKA_K_GRP_JOIN,
      SRKA_K_GRP_LEAVE,
      SRKA_K_NODE_PROMO
   } srka_kind_t;

   // functional state of the node
   typedef enum logic [1:0] {
      SRKA_DISC,
      SRKA_LEAF,
      SRKA_RELAY
   } srka_role_t;

   // one alive packet held for hop retransmission
   typedef struct packed {
      logic busy;
      logic up;
      logic due;
      logic [7:0] seq;
      logic [3:0] rtl;
      logic [3:0] cnt;
      logic [3:0] rec;
   } srka_slot_t;

endpackage : srka_pkg

// ---- design/srka_engine.sv ----
// Notes on behaviour
// - second promotion for dual beacons sends promotion packets with dual flag one
// - second promotion request carries own local switch identifier in switch id field
// - demotion with dual flag 1 stops named beacon; flag 0 demotes fully to leaf
// - after dual slot allocation broadcasts go twice; one copy stops on demotion
// - same data received in both modulations is detected and duplicate discarded
// - demotion packets carry own identifier, attachment ignored, modulation sent as zero for full demotion
// - completed demotion stops beacons at once and changes relay to leaf
// - single liveness timer; expiry means unregistered and disconnected state
// - timer loads from registration response, refreshed by alive and promotion requests
// - leaf restarts timer on new reliable data or connection/group control to itself
// - relay restarts timer when transmitting alive response for node below
// - relay retransmits unacknowledged alive at most limit times, one frame apart
// - received alive request or response gets link acknowledgement at once, priority 0
// - retransmitted alive is acknowledged again but not forwarded
// - exhausted downward alive request starts alive response toward coordinator
// - decrement remaining-retransmission field per retry; discard when already zero
// - hop counts fill records level 1 onward; nearest hops sum into first
// - invalid uplink records ignored; first alive exchange after registration invalid
// - relay queues configured count of alive requests and of responses
// - alternate alive flag from registration is honoured for legacy mode
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "srka_defs.svh"

module srka_engine
   import srka_pkg::*;
#(
   parameter int CONC = 2
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_tick,
   input wire logic rx_valid,
   input wire srka_kind_t rx_kind,
   input wire logic rx_for_self,
   input wire logic rx_ds,
   input wire logic rx_mod,
   input wire logic [15:0] rx_time,
   input wire logic [7:0] rx_seq,
   input wire logic [3:0] rx_rtl,
   input wire logic [3:0] rx_depth,
   input wire logic [3:0] rx_rec_num,
   input wire logic rx_valu,
   input wire logic [7:0] rx_uprec,
   input wire logic rx_new,
   input wire logic rx_alt_flag,
   input wire logic rx_data_valid,
   input wire logic rx_data_mod,
   input wire logic [15:0] rx_data_tag,
   output logic tx_valid,
   output srka_kind_t tx_kind,
   output logic tx_ds,
   output logic tx_mod,
   output logic [7:0] tx_sid,
   output logic [7:0] tx_seq,
   output logic [3:0] tx_rtl,
   output logic [3:0] tx_retx,
   output logic [3:0] tx_rec,
   output logic tx_prio0,
   output logic rx_data_drop,
   output logic bcast_twice,
   output srka_role_t role,
   output logic beacon_a_on,
   output logic beacon_b_on
);

   localparam int NS = 2 * CONC;

   typedef struct packed {
      srka_role_t role;
      logic reg_ok;
      logic bcn_a;
      logic bcn_b;
      logic bcast;
      logic legacy;
      logic valu;
      logic first_alv;
      logic [15:0] tmr;
      logic [15:0] last_t;
      logic [7:0] local_switch_identifier;
      logic [3:0] lvl;
      logic [3:0] hop_lim;
      logic dual_go;
      logic dual_mod;
      logic dem_go;
      logic dem_ds;
      logic dem_mod;
      logic ack_go;
      logic [7:0] ack_seq;
      logic rsp_go;
      logic [7:0] rsp_seq;
      logic last_ok;
      logic [7:0] last_seq;
      logic [7:0] uprec;
      logic [7:0] drops;
      logic dat_ok;
      logic dat_mod;
      logic [15:0] dat_tag;
      srka_slot_t [NS-1:0] sl;
      logic tx_v;
      srka_kind_t tx_k;
      logic tx_ds;
      logic tx_mod;
      logic [7:0] tx_sid;
      logic [7:0] tx_seq;
      logic [3:0] tx_rtl;
      logic [3:0] tx_retx;
      logic [3:0] tx_rec;
      logic tx_p0;
      logic drop;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } srka_st_t;

   srka_st_t q;
   srka_st_t d;
   logic sent;
   logic found;
   logic dup;
   logic [3:0] rec_i;

   // record slot for this hop; hops nearest the coordinator share record 0
   function automatic logic [3:0] rec_slot(input logic [3:0] lvl, input logic [3:0] depth,
                                           input logic [3:0] num);
      logic [3:0] skip;
      skip = (depth > num) ? 4'(depth - num) : 4'h0;
      if (lvl <= 4'(skip + 4'h1))
         rec_slot = 4'h0;
      else
         rec_slot = 4'(lvl - skip - 4'h1);
   endfunction : rec_slot

   function automatic logic hit(input logic [7:0] a);
      hit = (a == `SRKA_OFF_CTRL) || (a == `SRKA_OFF_CFG) ||
            (a == `SRKA_OFF_STATUS) || (a == `SRKA_OFF_TIMER);
   endfunction : hit

   always_comb
   begin
      d = q;
      sent = 1'b0;
      found = 1'b0;
      dup = q.last_ok && (rx_seq == q.last_seq);
      rec_i = rec_slot(q.lvl, rx_depth, rx_rec_num);
      d.tx_v = 1'b0;
      d.tx_p0 = 1'b0;
      d.drop = 1'b0;
      d.pready = 1'b0;
      d.pslverr = 1'b0;

      // liveness timer counts frames down
      if (frame_tick && q.reg_ok)
      begin
         if (q.tmr <= 16'h0001)
         begin
            d.reg_ok = 1'b0;
            d.role = SRKA_DISC;
            d.bcn_a = 1'b0;
            d.bcn_b = 1'b0;
            d.tmr = 16'h0000;
            d.sl = '0;
         end
         else
            d.tmr = q.tmr - 16'h0001;
      end

      // transmit arbitration; link acks go first so they leave at once
      if (q.ack_go)
      begin
         d.ack_go = 1'b0;
         d.tx_v = 1'b1;
         d.tx_k = SRKA_K_ALV_ACK;
         d.tx_seq = q.ack_seq;
         d.tx_p0 = 1'b1;
         sent = 1'b1;
      end
      else if (q.dual_go)
      begin
         d.dual_go = 1'b0;
         d.tx_v = 1'b1;
         d.tx_k = SRKA_K_NODE_PROMO;
         d.tx_ds = 1'b1;
         d.tx_mod = q.dual_mod;
         d.tx_sid = q.local_switch_identifier;
         sent = 1'b1;
      end
      else if (q.dem_go)
      begin
         // own identifier, modulation zero unless partial
         d.dem_go = 1'b0;
         d.tx_v = 1'b1;
         d.tx_k = SRKA_K_DEMOTE;
         d.tx_ds = q.dem_ds;
         d.tx_mod = q.dem_ds & q.dem_mod;
         d.tx_sid = q.local_switch_identifier;
         sent = 1'b1;
      end
      else if (q.rsp_go)
      begin
         d.rsp_go = 1'b0;
         d.tx_v = 1'b1;
         d.tx_k = SRKA_K_ALV_RSP;
         d.tx_seq = q.rsp_seq;
         d.tx_sid = q.local_switch_identifier;
         sent = 1'b1;
      end
      for (int i = 0; i < NS; i++)
         if (!sent && q.sl[i].busy && q.sl[i].due)
         begin
            sent = 1'b1;
            d.sl[i].due = 1'b0;
            d.tx_v = 1'b1;
            d.tx_k = q.sl[i].up ? SRKA_K_ALV_RSP : SRKA_K_ALV_REQ;
            d.tx_seq = q.sl[i].seq;
            d.tx_rtl = q.sl[i].rtl;
            d.tx_retx = q.sl[i].cnt;
            d.tx_rec = q.sl[i].rec;
            d.tx_sid = q.local_switch_identifier;
            if (q.sl[i].up && q.reg_ok)
               d.tmr = q.last_t;
         end

      // hop retransmission, one frame between attempts; after arbitration so a new response is not cleared
      if (frame_tick)
         for (int i = 0; i < NS; i++)
            if (q.sl[i].busy && !q.sl[i].due)
            begin
               if (q.sl[i].cnt >= q.hop_lim)
               begin
                  d.sl[i].busy = 1'b0;
                  if (!q.sl[i].up)
                  begin
                     d.rsp_go = 1'b1;
                     d.rsp_seq = q.sl[i].seq;
                  end
               end
               else if (q.sl[i].rtl == 4'h0)
                  d.sl[i].busy = 1'b0;
               else
               begin
                  d.sl[i].rtl = q.sl[i].rtl - 4'h1;
                  d.sl[i].cnt = q.sl[i].cnt + 4'h1;
                  d.sl[i].due = 1'b1;
               end
            end

      // register bus: answer one cycle after setup
      if (psel && !penable)
      begin
         d.pready = 1'b1;
         d.pslverr = !hit(paddr);
         case (paddr)
            `SRKA_OFF_CTRL: d.prdata = {15'h0000, q.dem_mod, q.dem_ds, q.dem_go, q.dual_mod, q.dual_go,
                                        q.lvl, q.local_switch_identifier};
            `SRKA_OFF_CFG: d.prdata = {28'h0000000, q.hop_lim};
            `SRKA_OFF_STATUS: d.prdata = {8'h00, q.uprec, q.drops, 1'b0, q.valu, q.legacy, q.reg_ok,
                                          q.bcn_b, q.bcn_a, q.role};
            `SRKA_OFF_TIMER: d.prdata = {q.last_t, q.tmr};
            default: d.prdata = 32'h00000000;
         endcase
      end
      if (psel && penable && q.pready && pwrite)
         case (paddr)
            `SRKA_OFF_CTRL:
            begin
               d.local_switch_identifier = pwdata[7:0];
               d.lvl = pwdata[`SRKA_CTRL_LVL_LO +: 4];
               // go bits only set; the engine clears them when sent
               if (pwdata[`SRKA_CTRL_DUAL_GO] && q.role == SRKA_RELAY)
               begin
                  d.dual_go = 1'b1;
                  d.dual_mod = pwdata[`SRKA_CTRL_DUAL_MOD];
               end
               if (pwdata[`SRKA_CTRL_DEM_GO] && q.role == SRKA_RELAY)
               begin
                  d.dem_go = 1'b1;
                  d.dem_ds = pwdata[`SRKA_CTRL_DEM_DS];
                  d.dem_mod = pwdata[`SRKA_CTRL_DEM_MOD];
               end
            end
            `SRKA_OFF_CFG: d.hop_lim = pwdata[3:0];
            default: d.hop_lim = q.hop_lim;
         endcase

      // same tag in the other modulation is a duplicate
      if (rx_data_valid)
      begin
         if (q.dat_ok && q.dat_tag == rx_data_tag && q.dat_mod != rx_data_mod)
         begin
            d.drop = 1'b1;
            d.dat_ok = 1'b0;
         end
         else
         begin
            d.dat_ok = 1'b1;
            d.dat_tag = rx_data_tag;
            d.dat_mod = rx_data_mod;
         end
      end

      // received control traffic; handled last so events win over clears
      if (rx_valid)
         case (rx_kind)
            SRKA_K_REGISTRATION_RESPONSE:
               if (rx_for_self)
               begin
                  d.tmr = rx_time;
                  d.last_t = rx_time;
                  d.legacy = rx_alt_flag;
                  if (!q.reg_ok)
                  begin
                     d.reg_ok = 1'b1;
                     d.role = SRKA_LEAF;
                     d.first_alv = 1'b1;
                     d.valu = 1'b0;
                  end
               end
            SRKA_K_PROMO_REQ:
               if (rx_for_self && q.reg_ok)
               begin
                  d.tmr = rx_time;
                  d.last_t = rx_time;
               end
            SRKA_K_PROMO_ACK:
               if (q.reg_ok)
               begin
                  d.role = SRKA_RELAY;
                  if (rx_mod)
                     d.bcn_b = 1'b1;
                  else
                     d.bcn_a = 1'b1;
               end
            SRKA_K_DEMOTE:
               if (q.role == SRKA_RELAY)
               begin
                  if (rx_ds)
                  begin
                     if (rx_mod)
                        d.bcn_b = 1'b0;
                     else
                        d.bcn_a = 1'b0;
                  end
                  else
                  begin
                     d.bcn_a = 1'b0;
                     d.bcn_b = 1'b0;
                     d.role = SRKA_LEAF;
                  end
               end
            SRKA_K_ALV_REQ, SRKA_K_ALV_RSP:
               if (q.reg_ok)
               begin
                  d.ack_go = 1'b1;
                  d.ack_seq = rx_seq;
                  d.last_ok = 1'b1;
                  d.last_seq = rx_seq;
                  if (rx_kind == SRKA_K_ALV_REQ && rx_for_self)
                  begin
                     d.tmr = rx_time;
                     d.last_t = rx_time;
                     if (!dup)
                     begin
                        d.valu = rx_valu && !q.first_alv;
                        if (rx_valu && !q.first_alv)
                           d.uprec = rx_uprec;
                        d.first_alv = 1'b0;
                        d.rsp_go = 1'b1;
                        d.rsp_seq = rx_seq;
                     end
                  end
                  else if (!dup && q.role == SRKA_RELAY && !q.legacy)
                  begin
                     for (int i = 0; i < NS; i++)
                        if (!found && !q.sl[i].busy &&
                            ((i >= CONC) == (rx_kind == SRKA_K_ALV_RSP)))
                        begin
                           found = 1'b1;
                           d.sl[i].busy = 1'b1;
                           d.sl[i].up = (rx_kind == SRKA_K_ALV_RSP);
                           d.sl[i].due = 1'b1;
                           d.sl[i].seq = rx_seq;
                           d.sl[i].rtl = rx_rtl;
                           d.sl[i].cnt = 4'h0;
                           d.sl[i].rec = rec_i;
                        end
                     if (!found)
                        d.drops = q.drops + 8'h01;
                  end
               end
            SRKA_K_ALV_ACK:
               for (int i = 0; i < NS; i++)
                  if (q.sl[i].busy && q.sl[i].seq == rx_seq)
                     d.sl[i].busy = 1'b0;
            SRKA_K_ARQ_DATA:
               // new reliable data for a leaf
               if (q.role == SRKA_LEAF && rx_for_self && rx_new)
                  d.tmr = q.last_t;
            SRKA_K_CONN_REQ, SRKA_K_CONN_CLS, SRKA_K_GRP_JOIN, SRKA_K_GRP_LEAVE:
               if (q.role == SRKA_LEAF && rx_for_self)
                  d.tmr = q.last_t;
            default: d.tmr = d.tmr;
         endcase

      // broadcasts doubled while both beacons run
      d.bcast = d.bcn_a && d.bcn_b;
   end

   // the whole state in one register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.hop_lim <= `SRKA_HOP_LIM_RST;
         q.local_switch_identifier <= `SRKA_LOCAL_SWITCH_IDENTIFIER_RST;
      end
      else
         q <= d;
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx_valid = q.tx_v;
   assign tx_kind = q.tx_k;
   assign tx_ds = q.tx_ds;
   assign tx_mod = q.tx_mod;
   assign tx_sid = q.tx_sid;
   assign tx_seq = q.tx_seq;
   assign tx_rtl = q.tx_rtl;
   assign tx_retx = q.tx_retx;
   assign tx_rec = q.tx_rec;
   assign tx_prio0 = q.tx_p0;
   assign rx_data_drop = q.drop;
   assign bcast_twice = q.bcast;
   assign role = q.role;
   assign beacon_a_on = q.bcn_a;
   assign beacon_b_on = q.bcn_b;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_alive_rx;
      rx_valid && q.reg_ok && (rx_kind == SRKA_K_ALV_REQ || rx_kind == SRKA_K_ALV_RSP);
   endsequence
   sequence s_ack_out;
      tx_valid && tx_kind == SRKA_K_ALV_ACK && tx_prio0;
   endsequence

   a_dual_flag: assert property (tx_valid && tx_kind == SRKA_K_NODE_PROMO |-> tx_ds)
      else $error("dual promotion without dual flag");
   a_promo_sid: assert property (tx_valid && tx_kind == SRKA_K_NODE_PROMO |-> tx_sid == q.local_switch_identifier)
      else $error("promotion id is not own id");
   a_partial_demote: assert property (rx_valid && rx_kind == SRKA_K_DEMOTE && rx_ds && !rx_mod &&
      q.role == SRKA_RELAY |=> !beacon_a_on && beacon_b_on == $past(q.bcn_b))
      else $error("partial demotion wrong beacon");
   a_bcast_twice: assert property (rx_valid && rx_kind == SRKA_K_PROMO_ACK && q.reg_ok && !frame_tick &&
      (rx_mod ? beacon_a_on : beacon_b_on) |=> bcast_twice)
      else $error("broadcast not doubled after second beacon");
   a_dup_discard: assert property (rx_data_valid && q.dat_ok && q.dat_tag == rx_data_tag &&
      q.dat_mod != rx_data_mod |=> rx_data_drop)
      else $error("duplicate data kept");
   a_demote_fields: assert property (tx_valid && tx_kind == SRKA_K_DEMOTE |->
      tx_sid == q.local_switch_identifier && (tx_ds || !tx_mod))
      else $error("demotion fields wrong");
   a_full_demote: assert property (rx_valid && rx_kind == SRKA_K_DEMOTE && !rx_ds &&
      q.role == SRKA_RELAY |=> role == SRKA_LEAF && !beacon_a_on && !beacon_b_on)
      else $error("full demotion incomplete");
   a_timer_expiry: assert property (frame_tick && q.reg_ok && q.tmr <= 16'h0001 && !rx_valid
      |=> role == SRKA_DISC && !q.reg_ok)
      else $error("timer expiry not handled");
   a_timer_load: assert property (rx_valid && rx_kind == SRKA_K_REGISTRATION_RESPONSE && rx_for_self
      |=> q.tmr == $past(rx_time))
      else $error("timer not loaded");
   a_ack_seq: assert property (s_alive_rx |-> ##2 tx_seq == $past(rx_seq, 2))
      else $error("ack carries wrong sequence");
   a_ack_prompt: assert property (s_alive_rx |-> ##2 s_ack_out)
      else $error("alive not acknowledged in time");
   a_retx_bound: assert property (tx_valid && tx_kind == SRKA_K_ALV_REQ |-> tx_retx <= q.hop_lim)
      else $error("too many retransmissions");

endmodule : srka_engine

// ---- sim/srka_partner.sv ----
`timescale 1ns/1ns

module srka_partner
   import srka_pkg::*;
(
   input wire logic sys_clk,
   input wire logic tx_valid,
   input wire srka_kind_t tx_kind,
   input wire logic [7:0] tx_seq,
   input wire logic ack_en,
   output logic rx_valid,
   output srka_kind_t rx_kind,
   output logic rx_for_self,
   output logic rx_ds,
   output logic rx_mod,
   output logic [15:0] rx_time,
   output logic [7:0] rx_seq,
   output logic [3:0] rx_rtl,
   output logic rx_new
);
   initial
   begin
      rx_valid = 0;
      rx_kind = SRKA_K_NONE;
      {rx_for_self, rx_ds, rx_mod, rx_time, rx_seq, rx_rtl, rx_new} = '0;
   end

   // one packet for one cycle; fields scrambled afterwards so stale values never look valid
   task automatic send(input srka_kind_t k, input logic s, input logic d, input logic m,
                       input logic [15:0] t, input logic [7:0] q, input logic [3:0] r);
      @(posedge sys_clk);
      rx_valid <= 1;
      {rx_kind, rx_for_self, rx_ds, rx_mod, rx_time, rx_seq, rx_rtl, rx_new} <= {k, s, d, m, t, q, r, 1'b1};
      @(posedge sys_clk);
      rx_valid <= 0;
      {rx_time, rx_seq, rx_rtl, rx_new} <= ~{t, q, r, 1'b1};
   endtask : send

   // next hop acks a forwarded alive promptly
   always @(posedge sys_clk)
   begin
      if (ack_en && tx_valid === 1'b1 && tx_kind === SRKA_K_ALV_REQ)
         send(SRKA_K_ALV_ACK, 1'b1, 1'b0, 1'b0, 16'h0000, tx_seq, 4'h0);
   end
endmodule : srka_partner

// ---- sim/srka_engine_test.sv ----
`timescale 1ns/1ns

module srka_engine_test
   import srka_pkg::*;
;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, frame_tick = 0, ack_en = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, rx_valid, rx_for_self, rx_ds, rx_mod, rx_new;
   logic rx_data_valid = 0, rx_data_mod = 0, rx_data_drop, bcast_twice, beacon_a_on, beacon_b_on;
   logic rx_valu = 0, rx_alt_flag = 0;
   logic [15:0] rx_time, rx_data_tag = '0;
   logic [7:0] rx_seq, tx_sid, tx_seq, rx_uprec = '0;
   logic [3:0] rx_rtl, tx_rtl, tx_retx, tx_rec;
   logic tx_valid, tx_ds, tx_mod, tx_prio0;
   srka_kind_t rx_kind, tx_kind;
   srka_role_t role;
   int checked = 0, num_errors = 0, n_fwd = 0, n;

   srka_engine #(.CONC(2)) u_srka_engine (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_tick(frame_tick), .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_for_self(rx_for_self), .rx_ds(rx_ds),
      .rx_mod(rx_mod), .rx_time(rx_time), .rx_seq(rx_seq), .rx_rtl(rx_rtl), .rx_depth(4'h4), .rx_rec_num(4'h3),
      .rx_valu(rx_valu), .rx_uprec(rx_uprec), .rx_new(rx_new), .rx_alt_flag(rx_alt_flag),
      .rx_data_valid(rx_data_valid),
      .rx_data_mod(rx_data_mod), .rx_data_tag(rx_data_tag), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_ds(tx_ds),
      .tx_mod(tx_mod), .tx_sid(tx_sid), .tx_seq(tx_seq), .tx_rtl(tx_rtl), .tx_retx(tx_retx), .tx_rec(tx_rec),
      .tx_prio0(tx_prio0), .rx_data_drop(rx_data_drop), .bcast_twice(bcast_twice), .role(role),
      .beacon_a_on(beacon_a_on), .beacon_b_on(beacon_b_on));
   srka_partner u_srka_partner (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_seq(tx_seq),
      .ack_en(ack_en), .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_for_self(rx_for_self), .rx_ds(rx_ds),
      .rx_mod(rx_mod), .rx_time(rx_time), .rx_seq(rx_seq), .rx_rtl(rx_rtl), .rx_new(rx_new));

   // forwarded alive requests, to prove that a copy was not sent
   always @(posedge sys_clk)
   begin
      if (tx_valid === 1'b1 && tx_kind === SRKA_K_ALV_REQ)
         n_fwd <= n_fwd + 1;
   end

   task automatic give_verdict;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      i = 0;
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge sys_clk);
      penable <= 1;
      do
      begin
         @(posedge sys_clk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1)
      begin
         num_errors++;
         give_verdict();
      end
   endtask : apb

   task automatic expect_tx(input srka_kind_t k, input int mx);
      bit ok;
      ok = 0;
      for (int i = 0; i < mx && !ok; i++)
      begin
         @(posedge sys_clk);
         #1;
         ok = (tx_valid === 1'b1) && (tx_kind === k);
      end
      if (!ok)
      begin
         $display("BAD tx kind exp %h got none", k);
         num_errors++;
         give_verdict();
      end
   endtask : expect_tx

   task automatic tick(input int c);
      repeat (c)
      begin
         @(posedge sys_clk);
         frame_tick <= 1;
         @(posedge sys_clk);
         frame_tick <= 0;
      end
   endtask : tick

   task automatic s_regs;
      apb(0, 8'h04, 0);
      chk("cfg reset", 32'h2, rd);
      apb(0, 8'h00, 0);
      chk("local_switch_identifier reset", 8'hff, rd[7:0]);
      apb(0, 8'h10, 0);
      chk("unmapped err", 1, er);
      apb(1, 8'h04, 32'h1);
      apb(0, 8'h04, 0);
      chk("cfg limit", 32'h1, rd);
   endtask : s_regs

   task automatic s_timer;
      {rx_valu, rx_uprec, rx_alt_flag} <= {1'b1, 8'h5a, 1'b1};
      u_srka_partner.send(SRKA_K_REGISTRATION_RESPONSE, 1, 0, 0, 16'h0003, 8'h00, 4'h0);
      apb(0, 8'h0c, 0);
      chk("timer load", 16'h3, rd[15:0]);
      tick(2);
      u_srka_partner.send(SRKA_K_ALV_REQ, 1, 0, 0, 16'h0004, 8'h01, 4'h1);
      expect_tx(SRKA_K_ALV_ACK, 2);
      chk("ack prio", 1, tx_prio0);
      apb(0, 8'h08, 0);
      chk("first alive invalid", 0, rd[6]);
      u_srka_partner.send(SRKA_K_ALV_REQ, 1, 0, 0, 16'h0004, 8'h02, 4'h1);
      apb(0, 8'h08, 0);
      chk("uplink record", {8'h5a, 1'b1}, {rd[23:16], rd[6]});
      apb(0, 8'h0c, 0);
      chk("timer refresh", 16'h4, rd[15:0]);
      tick(3);
      apb(0, 8'h08, 0);
      chk("still registered", 2'h3, rd[5:4]);
      tick(1);
      apb(0, 8'h08, 0);
      chk("expired state", 5'h00, rd[4:0]);
   endtask : s_timer

   task automatic s_dup;
      @(posedge sys_clk);
      {rx_data_valid, rx_data_mod, rx_data_tag} <= {2'b10, 16'h1234};
      @(posedge sys_clk);
      rx_data_mod <= 1;
      #1;
      chk("first kept", 0, rx_data_drop);
      @(posedge sys_clk);
      rx_data_valid <= 0;
      #1;
      chk("copy dropped", 1, rx_data_drop);
   endtask : s_dup

   task automatic s_relay;
      rx_alt_flag <= 1'b0;
      u_srka_partner.send(SRKA_K_REGISTRATION_RESPONSE, 1, 0, 0, 16'h0100, 8'h00, 4'h0);
      u_srka_partner.send(SRKA_K_PROMO_ACK, 1, 0, 0, 16'h0100, 8'h00, 4'h0);
      apb(0, 8'h08, 0);
      chk("relay role", 2'h2, rd[1:0]);
      apb(1, 8'h00, 32'h0000_03ff);
      u_srka_partner.send(SRKA_K_ALV_REQ, 0, 0, 0, 16'h0100, 8'h05, 4'h3);
      expect_tx(SRKA_K_ALV_ACK, 2);
      expect_tx(SRKA_K_ALV_REQ, 6);
      chk("fwd fields", {8'h05, 4'h3, 4'h0, 4'h1}, {tx_seq, tx_rtl, tx_retx, tx_rec});
      u_srka_partner.send(SRKA_K_ALV_REQ, 0, 0, 0, 16'h0100, 8'h05, 4'h3);
      n = n_fwd;
      expect_tx(SRKA_K_ALV_ACK, 2);
      repeat (4) @(posedge sys_clk);
      chk("repeat not fwd", n, n_fwd);
      tick(1);
      expect_tx(SRKA_K_ALV_REQ, 4);
      chk("retry fields", {4'h2, 4'h1}, {tx_rtl, tx_retx});
      tick(1);
      expect_tx(SRKA_K_ALV_RSP, 4);
      chk("rsp seq", 8'h05, tx_seq);
   endtask : s_relay

   task automatic s_cancel;
      ack_en = 1;
      u_srka_partner.send(SRKA_K_ALV_REQ, 0, 0, 0, 16'h0100, 8'h09, 4'h3);
      expect_tx(SRKA_K_ALV_REQ, 8);
      repeat (4) @(posedge sys_clk);
      n = n_fwd;
      tick(2);
      repeat (4) @(posedge sys_clk);
      chk("acked no retry", n, n_fwd);
      ack_en = 0;
   endtask : s_cancel

   task automatic s_dual;
      apb(1, 8'h00, 32'h0000_3121);
      expect_tx(SRKA_K_NODE_PROMO, 8);
      chk("dual flag sid", {1'b1, 8'h21}, {tx_ds, tx_sid});
      u_srka_partner.send(SRKA_K_PROMO_ACK, 1, 1, 1, 16'h0100, 8'h00, 4'h0);
      repeat (2) @(posedge sys_clk);
      chk("two beacons", 3'h7, {bcast_twice, beacon_a_on, beacon_b_on});
   endtask : s_dual

   task automatic s_demote;
      apb(1, 8'h00, 32'h0000_c121);
      expect_tx(SRKA_K_DEMOTE, 8);
      chk("partial demote", {1'b1, 1'b0, 8'h21}, {tx_ds, tx_mod, tx_sid});
      u_srka_partner.send(SRKA_K_DEMOTE, 1, 1, 0, 16'h0100, 8'h00, 4'h0);
      repeat (2) @(posedge sys_clk);
      chk("one beacon left", 3'h1, {bcast_twice, beacon_a_on, beacon_b_on});
      apb(1, 8'h00, 32'h0001_4121);
      expect_tx(SRKA_K_DEMOTE, 8);
      chk("full demote", {1'b0, 1'b0, 8'h21}, {tx_ds, tx_mod, tx_sid});
      u_srka_partner.send(SRKA_K_DEMOTE, 1, 0, 0, 16'h0100, 8'h00, 4'h0);
      repeat (2) @(posedge sys_clk);
      chk("leaf again", 4'h4, {role, beacon_a_on, beacon_b_on});
   endtask : s_demote

   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end

   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1;
      s_regs();
      s_timer();
      s_dup();
      s_relay();
      s_cancel();
      s_dual();
      s_demote();
      give_verdict();
   end
endmodule : srka_engine_test
